// file: ccm_input_chan.sv
// Purpose: Input path of one channel: routing, digital filter, prescaler
// Assumes: All inputs already in the timer clock domain
// Notes:   Capture event is a one-cycle pulse on each counted rising edge
module ccm_input_chan (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       arst_n_in,
	input  wire logic       ce_in,
	// Configuration
	input  wire logic [1:0] dir_sel_in,
	input  wire logic [1:0] prescale_in,
	input  wire logic [3:0] filter_in,
	input  wire logic       capture_en_in,
	// Sources
	input  wire logic       src_direct_in,
	input  wire logic       src_cross_in,
	input  wire logic       src_trig_in,
	// Results
	output logic            capture_input_out,
	output logic            capture_event_out
);

	typedef struct packed {
		logic [5:0] div_cnt;
		logic [3:0] run;
		logic       last;
		logic       filt;
		logic       filt_d;
		logic [2:0] psc;
		logic       evt;
	} chan_state_t;

	chan_state_t st_r;
	chan_state_t st_nxt;
	logic        raw;
	logic [5:0]  div;
	logic [3:0]  len;
	logic [2:0]  limit;

	// ----------------------------------------------------------------
	// Input routing
	// ----------------------------------------------------------------
	always_comb begin
		case (ccm_pkg::dir_t'(dir_sel_in))
			ccm_pkg::DIR_DIRECT: raw = src_direct_in;
			ccm_pkg::DIR_CROSS:  raw = src_cross_in;
			ccm_pkg::DIR_TRIG:   raw = src_trig_in;
			default:             raw = 1'b0;
		endcase
	end

	assign div   = ccm_pkg::FILT_DIV[filter_in];
	assign len   = ccm_pkg::FILT_LEN[filter_in];
	assign limit = 3'b111 >> (2'd3 - prescale_in);

	// ----------------------------------------------------------------
	// Filter and prescaler
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt        = st_r;
		st_nxt.evt    = 1'b0;
		st_nxt.filt_d = st_r.filt;
		if (filter_in == 4'h0) begin
			st_nxt.filt = raw;
		end else if (st_r.div_cnt >= div - 6'h01) begin
			st_nxt.div_cnt = 6'h00;
			st_nxt.last    = raw;
			if (raw == st_r.last) begin
				if (st_r.run != 4'h8) begin
					st_nxt.run = st_r.run + 4'h1;
				end
			end else begin
				st_nxt.run = 4'h1;
			end
			if (st_nxt.run >= len) begin
				st_nxt.filt = raw;
			end
		end else begin
			st_nxt.div_cnt = st_r.div_cnt + 6'h01;
		end
		if (dir_sel_in == 2'b00 || !capture_en_in) begin
			st_nxt.psc = 3'h0;
		end else if (st_r.filt && !st_r.filt_d) begin
			if (st_r.psc >= limit) begin
				st_nxt.psc = 3'h0;
				st_nxt.evt = 1'b1;
			end else begin
				st_nxt.psc = st_r.psc + 3'h1;
			end
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r <= '0;
		end else if (ce_in) begin
			st_r <= st_nxt;
		end
	end

	assign capture_input_out = st_r.filt;
	assign capture_event_out = st_r.evt;

endmodule : ccm_input_chan

// file: ccm_mode_asserts.sv
// Purpose: Port-level checks of the channel c/d mode block
// Assumes: ce_in held high by the bench
// Notes:   Bound to every ccm_mode_top instance
module ccm_mode_asserts (
	// Observed ports
	input wire logic       clock_in,
	input wire logic       arst_n_in,
	input wire logic       avs_read_in,
	input wire logic       avs_write_in,
	input wire logic       avs_waitrequest_out,
	input wire logic       ext_trigger_filtered_in,
	input wire logic       chan_c_ref_raw_in,
	input wire logic       chan_d_ref_raw_in,
	input wire logic       chan_c_fast_enable_out,
	input wire logic       chan_c_preload_enable_out,
	input wire logic [2:0] chan_c_compare_mode_out,
	input wire logic [2:0] chan_d_compare_mode_out,
	input wire logic       chan_c_reference_out,
	input wire logic       chan_d_reference_out,
	input wire logic       chan_c_enable_bit_out,
	input wire logic       chan_d_enable_bit_out,
	input wire logic [1:0] chan_c_direction_sel_out,
	input wire logic [1:0] chan_d_direction_sel_out,
	input wire logic       capture_event_c_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	property p_wait;
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
	property p_lock_c;
		$changed(chan_c_direction_sel_out) |-> !$past(chan_c_enable_bit_out);
	endproperty
	a_lock_c: assert property (p_lock_c) else $error("c direction changed");
	property p_lock_d;
		$changed(chan_d_direction_sel_out) |-> !$past(chan_d_enable_bit_out);
	endproperty
	a_lock_d: assert property (p_lock_d) else $error("d direction changed");
	property p_cfg_c;
		chan_c_direction_sel_out != 2'b00 |-> !chan_c_fast_enable_out
			&& !chan_c_preload_enable_out && chan_c_compare_mode_out == 3'h0;
	endproperty
	a_cfg_c: assert property (p_cfg_c) else $error("c compare set in input");
	property p_cfg_d;
		chan_d_direction_sel_out != 2'b00 |-> chan_d_compare_mode_out == 3'h0;
	endproperty
	a_cfg_d: assert property (p_cfg_d) else $error("d compare set in input");
	property p_ref_c;
		!ext_trigger_filtered_in |=> chan_c_reference_out == $past(chan_c_ref_raw_in);
	endproperty
	a_ref_c: assert property (p_ref_c) else $error("c reference wrong");
	property p_ref_d;
		!ext_trigger_filtered_in |=> chan_d_reference_out == $past(chan_d_ref_raw_in);
	endproperty
	a_ref_d: assert property (p_ref_d) else $error("d reference wrong");
	property p_ev_c;
		capture_event_c_out |=> !capture_event_c_out;
	endproperty
	a_ev_c: assert property (p_ev_c) else $error("c event too long");
	property p_ev_en;
		capture_event_c_out |-> chan_c_enable_bit_out && chan_c_direction_sel_out != 2'b00;
	endproperty
	a_ev_en: assert property (p_ev_en) else $error("c event while off");
endmodule : ccm_mode_asserts

bind ccm_mode_top ccm_mode_asserts u_chk (.clock_in, .arst_n_in, .avs_read_in,
	.avs_write_in, .avs_waitrequest_out, .ext_trigger_filtered_in, .chan_c_ref_raw_in,
	.chan_d_ref_raw_in, .chan_c_fast_enable_out, .chan_c_preload_enable_out,
	.chan_c_compare_mode_out, .chan_d_compare_mode_out, .chan_c_reference_out,
	.chan_d_reference_out, .chan_c_enable_bit_out, .chan_d_enable_bit_out,
	.chan_c_direction_sel_out, .chan_d_direction_sel_out, .capture_event_c_out);

// file: ccm_mode_top.sv
// Purpose: Capture/compare mode register for channels c and d, with bus slave
// Assumes: Avalon-MM slave, byte addresses, one wait state per access
// Notes:   Channel enable bits sit in a companion register in this block
//
// Implementation choice: the Avalon-MM slave port.
module ccm_mode_top (
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        arst_n_in,
	input  wire logic        ce_in,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// Timer inputs and trigger sources
	input  wire logic        timer_input_c_in,
	input  wire logic        timer_input_d_in,
	input  wire logic        internal_trigger_src_in,
	input  wire logic        ext_trigger_filtered_in,
	input  wire logic        chan_c_ref_raw_in,
	input  wire logic        chan_d_ref_raw_in,
	// Output compare configuration
	output logic             chan_c_fast_enable_out,
	output logic             chan_c_preload_enable_out,
	output logic      [2:0]  chan_c_compare_mode_out,
	output logic             chan_d_fast_enable_out,
	output logic             chan_d_preload_enable_out,
	output logic      [2:0]  chan_d_compare_mode_out,
	output logic             chan_c_reference_out,
	output logic             chan_d_reference_out,
	// Channel state
	output logic             chan_c_enable_bit_out,
	output logic             chan_d_enable_bit_out,
	output logic      [1:0]  chan_c_direction_sel_out,
	output logic      [1:0]  chan_d_direction_sel_out,
	// Input capture results
	output logic             capture_input_c_out,
	output logic             capture_input_d_out,
	output logic             capture_event_c_out,
	output logic             capture_event_d_out
);

	typedef struct packed {
		logic [15:0] mode;
		logic [1:0]  enable;
		logic        ack;
		logic [31:0] rdata;
		logic [2:0]  sync_c;
		logic [2:0]  sync_d;
		logic        tin_c;
		logic        tin_d;
		logic        ref_c;
		logic        ref_d;
	} top_state_t;

	top_state_t st_r;
	top_state_t st_nxt;
	logic       req;
	logic       hit_mode;
	logic       hit_enable;
	logic [7:0] byte_c;
	logic [7:0] byte_d;
	logic       out_c;
	logic       out_d;

	assign req        = avs_read_in | avs_write_in;
	assign hit_mode   = (avs_address_in == ccm_pkg::MODE_OFFSET);
	assign hit_enable = (avs_address_in == ccm_pkg::ENABLE_OFFSET);
	assign byte_c     = st_r.mode[7:0];
	assign byte_d     = st_r.mode[15:8];
	assign out_c      = (byte_c[1:0] == 2'b00);
	assign out_d      = (byte_d[1:0] == 2'b00);

	// ----------------------------------------------------------------
	// Bus slave and register update
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt     = st_r;
		st_nxt.ack = req & ~st_r.ack;
		if (req && !st_r.ack) begin
			if (hit_mode) begin
				st_nxt.rdata = {16'h0000, st_r.mode};
			end else if (hit_enable) begin
				st_nxt.rdata = '0;
				st_nxt.rdata[ccm_pkg::EN_C_POS] = st_r.enable[0];
				st_nxt.rdata[ccm_pkg::EN_D_POS] = st_r.enable[1];
			end else begin
				st_nxt.rdata = '0;
			end
		end
		if (avs_write_in && st_r.ack && hit_mode) begin
			if (avs_byteenable_in[0]) begin
				st_nxt.mode[7:2] = avs_writedata_in[7:2];
				if (!st_r.enable[0]) begin
					st_nxt.mode[1:0] = avs_writedata_in[1:0];
				end
			end
			if (avs_byteenable_in[1]) begin
				st_nxt.mode[15:10] = avs_writedata_in[15:10];
				if (!st_r.enable[1]) begin
					st_nxt.mode[9:8] = avs_writedata_in[9:8];
				end
			end
		end else if (avs_write_in && st_r.ack && hit_enable) begin
			if (avs_byteenable_in[1]) begin
				st_nxt.enable[0] = avs_writedata_in[ccm_pkg::EN_C_POS];
				st_nxt.enable[1] = avs_writedata_in[ccm_pkg::EN_D_POS];
			end
		end
		// Pin synchronisers: a level is taken once stages two and three agree
		st_nxt.sync_c = {st_r.sync_c[1:0], timer_input_c_in};
		st_nxt.sync_d = {st_r.sync_d[1:0], timer_input_d_in};
		if (st_r.sync_c[2] == st_r.sync_c[1]) begin
			st_nxt.tin_c = st_r.sync_c[2];
		end
		if (st_r.sync_d[2] == st_r.sync_d[1]) begin
			st_nxt.tin_d = st_r.sync_d[2];
		end
		// Reference clear by filtered external trigger
		st_nxt.ref_c = chan_c_ref_raw_in
			& ~(out_c & byte_c[ccm_pkg::CLEAR_POS] & ext_trigger_filtered_in);
		st_nxt.ref_d = chan_d_ref_raw_in
			& ~(out_d & byte_d[ccm_pkg::CLEAR_POS] & ext_trigger_filtered_in);
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r        <= '0;
			st_r.mode   <= ccm_pkg::MODE_RESET;
			st_r.enable <= ccm_pkg::ENABLE_RESET;
		end else if (ce_in) begin
			st_r <= st_nxt;
		end
	end

	assign avs_waitrequest_out = req & ~st_r.ack;
	assign avs_readdata_out    = st_r.rdata;

	// ----------------------------------------------------------------
	// Output compare view; fast, preload and mode masked while the channel is an input
	// ----------------------------------------------------------------
	assign chan_c_fast_enable_out    = out_c & byte_c[ccm_pkg::FAST_POS];
	assign chan_c_preload_enable_out = out_c & byte_c[ccm_pkg::PRELOAD_POS];
	assign chan_c_compare_mode_out   = out_c ? byte_c[ccm_pkg::CMPMODE_LSB +: 3] : 3'h0;
	assign chan_d_fast_enable_out    = out_d & byte_d[ccm_pkg::FAST_POS];
	assign chan_d_preload_enable_out = out_d & byte_d[ccm_pkg::PRELOAD_POS];
	assign chan_d_compare_mode_out   = out_d ? byte_d[ccm_pkg::CMPMODE_LSB +: 3] : 3'h0;
	assign chan_c_reference_out      = st_r.ref_c;
	assign chan_d_reference_out      = st_r.ref_d;
	assign chan_c_enable_bit_out     = st_r.enable[0];
	assign chan_d_enable_bit_out     = st_r.enable[1];
	assign chan_c_direction_sel_out  = byte_c[ccm_pkg::DIR_LSB +: 2];
	assign chan_d_direction_sel_out  = byte_d[ccm_pkg::DIR_LSB +: 2];

	// ----------------------------------------------------------------
	// Input capture paths
	// ----------------------------------------------------------------
	ccm_input_chan u_chan_c (
		.clock_in          (clock_in),
		.arst_n_in         (arst_n_in),
		.ce_in             (ce_in),
		.dir_sel_in        (byte_c[ccm_pkg::DIR_LSB +: 2]),
		.prescale_in       (byte_c[ccm_pkg::PSC_LSB +: 2]),
		.filter_in         (byte_c[ccm_pkg::FILTER_LSB +: 4]),
		.capture_en_in     (st_r.enable[0]),
		.src_direct_in     (st_r.tin_c),
		.src_cross_in      (st_r.tin_d),
		.src_trig_in       (internal_trigger_src_in),
		.capture_input_out (capture_input_c_out),
		.capture_event_out (capture_event_c_out)
	);

	ccm_input_chan u_chan_d (
		.clock_in          (clock_in),
		.arst_n_in         (arst_n_in),
		.ce_in             (ce_in),
		.dir_sel_in        (byte_d[ccm_pkg::DIR_LSB +: 2]),
		.prescale_in       (byte_d[ccm_pkg::PSC_LSB +: 2]),
		.filter_in         (byte_d[ccm_pkg::FILTER_LSB +: 4]),
		.capture_en_in     (st_r.enable[1]),
		.src_direct_in     (st_r.tin_d),
		.src_cross_in      (st_r.tin_c),
		.src_trig_in       (internal_trigger_src_in),
		.capture_input_out (capture_input_d_out),
		.capture_event_out (capture_event_d_out)
	);

endmodule : ccm_mode_top

// file: ccm_pkg.sv
// Purpose: Shared constants for the channel 3/4 capture/compare mode block
// Assumes: 32-bit Avalon-MM register bus with byte addresses
// Notes:   Timer clock is also the filter sampling base clock
package ccm_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  MODE_OFFSET   = 8'h1C;
	localparam logic [7:0]  ENABLE_OFFSET = 8'h20;
	localparam logic [15:0] MODE_RESET    = 16'h0000;
	localparam logic [1:0]  ENABLE_RESET  = 2'h0;

	// ----------------------------------------------------------------
	// Mode register fields, byte of channel c at 7:0, channel d at 15:8
	// ----------------------------------------------------------------
	localparam int DIR_LSB      = 0;
	localparam int FAST_POS     = 2;
	localparam int PRELOAD_POS  = 3;
	localparam int CMPMODE_LSB  = 4;
	localparam int CLEAR_POS    = 7;
	localparam int PSC_LSB      = 2;
	localparam int FILTER_LSB   = 4;
	localparam int CHAN_D_SHIFT = 8;

	// ----------------------------------------------------------------
	// Enable register fields
	// ----------------------------------------------------------------
	localparam int EN_C_POS = 8;
	localparam int EN_D_POS = 12;

	// ----------------------------------------------------------------
	// Direction codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DIR_OUTPUT = 2'b00,
		DIR_DIRECT = 2'b01,
		DIR_CROSS  = 2'b10,
		DIR_TRIG   = 2'b11
	} dir_t;

	// ----------------------------------------------------------------
	// Filter tables indexed by filter code: sample divider and length
	// ----------------------------------------------------------------
	localparam logic [15:0][5:0] FILT_DIV = {
		6'h20, 6'h20, 6'h20, 6'h10, 6'h10, 6'h10, 6'h08, 6'h08,
		6'h04, 6'h04, 6'h02, 6'h02, 6'h01, 6'h01, 6'h01, 6'h01
	};
	localparam logic [15:0][3:0] FILT_LEN = {
		4'h8, 4'h6, 4'h5, 4'h8, 4'h6, 4'h5, 4'h8, 4'h6,
		4'h8, 4'h6, 4'h8, 4'h6, 4'h8, 4'h4, 4'h2, 4'h1
	};

endpackage : ccm_pkg

// file: testbench.sv
// Purpose: Register and capture tests of the channel c/d mode block
// Assumes: One wait state per bus access
// Notes:   Capture events counted over eight source pulses
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %h seen %h", nm, e, s); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in, arst_n_in, ce_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic [7:0]  avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rdata;
	logic [3:0]  avs_byteenable_in;
	logic timer_input_c_in, timer_input_d_in, internal_trigger_src_in, ext_trigger_filtered_in;
	logic chan_c_ref_raw_in, chan_d_ref_raw_in, chan_c_fast_enable_out;
	logic chan_c_preload_enable_out, chan_d_fast_enable_out, chan_d_preload_enable_out;
	logic [2:0] chan_c_compare_mode_out, chan_d_compare_mode_out;
	logic chan_c_reference_out, chan_d_reference_out, chan_c_enable_bit_out;
	logic chan_d_enable_bit_out, capture_input_c_out, capture_input_d_out;
	logic capture_event_c_out, capture_event_d_out;
	logic [1:0] chan_c_direction_sel_out, chan_d_direction_sel_out;
	int fail_count, comparisons, cycles, cnt_c, cnt_d, c0, d0;
	logic [15:0] cm [8] = '{16'h0201, 16'h0205, 16'h0209, 16'h020D, 16'h0103, 16'h0302,
		16'h02F1, 16'h0211};
	int          ec [8] = '{8, 4, 2, 1, 8, 8, 0, 8};
	logic [2:0]  src [8] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h6, 3'h6, 3'h1, 3'h1};
	ccm_mode_top u_dut (.clock_in, .arst_n_in, .ce_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
		.avs_waitrequest_out, .timer_input_c_in, .timer_input_d_in, .internal_trigger_src_in,
		.ext_trigger_filtered_in, .chan_c_ref_raw_in, .chan_d_ref_raw_in,
		.chan_c_fast_enable_out, .chan_c_preload_enable_out, .chan_c_compare_mode_out,
		.chan_d_fast_enable_out, .chan_d_preload_enable_out, .chan_d_compare_mode_out,
		.chan_c_reference_out, .chan_d_reference_out, .chan_c_enable_bit_out,
		.chan_d_enable_bit_out, .chan_c_direction_sel_out, .chan_d_direction_sel_out,
		.capture_input_c_out, .capture_input_d_out, .capture_event_c_out,
		.capture_event_d_out);
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	// Cycle ceiling and capture event counters
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (capture_event_c_out === 1'b1) cnt_c <= cnt_c + 1;
		if (capture_event_d_out === 1'b1) cnt_d <= cnt_d + 1;
		if (cycles == 5000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic conclude();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	// Holds the request until waitrequest is seen low
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] b);
		@(posedge clock_in);
		avs_address_in <= a;
		avs_write_in <= w;
		avs_read_in <= !w;
		avs_writedata_in <= d;
		avs_byteenable_in <= b;
		do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
		rdata = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		bus(a, 1'b1, d, b);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0000_0000, 4'hF);
		`CHK("readdata", e, rdata)
	endtask : rd
	task automatic pulses(input logic [2:0] m);
		repeat (8) begin
			@(posedge clock_in);
			{internal_trigger_src_in, timer_input_d_in, timer_input_c_in} <= m;
			repeat (4) @(posedge clock_in);
			{internal_trigger_src_in, timer_input_d_in, timer_input_c_in} <= 3'h0;
			repeat (5) @(posedge clock_in);
		end
		repeat (8) @(posedge clock_in);
	endtask : pulses
	initial begin
		{avs_address_in, avs_read_in, avs_write_in, avs_writedata_in, avs_byteenable_in} = '0;
		{timer_input_c_in, timer_input_d_in, internal_trigger_src_in} = 3'h0;
		{ext_trigger_filtered_in, chan_c_ref_raw_in, chan_d_ref_raw_in} = 3'h0;
		ce_in = 1'b1;
		arst_n_in = 1'b0;
		repeat (3) @(posedge clock_in);
		arst_n_in <= 1'b1;
		rd(8'h1C, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000);
		rd(8'h44, 32'h0000_0000);
		wr(8'h1C, 32'h0000_58AC, 4'h3);
		@(negedge clock_in);
		`CHK("fast_c", 1'b1, chan_c_fast_enable_out)
		`CHK("preload_c", 1'b1, chan_c_preload_enable_out)
		`CHK("mode_c", 3'h2, chan_c_compare_mode_out)
		`CHK("fast_d", 1'b0, chan_d_fast_enable_out)
		`CHK("preload_d", 1'b1, chan_d_preload_enable_out)
		`CHK("mode_d", 3'h5, chan_d_compare_mode_out)
		@(posedge clock_in);
		{ext_trigger_filtered_in, chan_c_ref_raw_in, chan_d_ref_raw_in} <= 3'h7;
		repeat (2) @(negedge clock_in);
		`CHK("ref_c", 1'b0, chan_c_reference_out)
		`CHK("ref_d", 1'b1, chan_d_reference_out)
		@(posedge clock_in);
		ext_trigger_filtered_in <= 1'b0;
		repeat (2) @(negedge clock_in);
		`CHK("ref_c", 1'b1, chan_c_reference_out)
		wr(8'h44, 32'hFFFF_FFFF, 4'hF);
		rd(8'h1C, 32'h0000_58AC);
		wr(8'h1C, 32'h0000_0201, 4'h3);
		rd(8'h1C, 32'h0000_0201);
		`CHK("dir_c", 2'h1, chan_c_direction_sel_out)
		`CHK("dir_d", 2'h2, chan_d_direction_sel_out)
		`CHK("fast_c", 1'b0, chan_c_fast_enable_out)
		wr(8'h20, 32'h0000_1100, 4'h2);
		rd(8'h20, 32'h0000_1100);
		wr(8'h1C, 32'h0000_FFFF, 4'h3);
		rd(8'h1C, 32'h0000_FEFD);
		`CHK("mode_d", 3'h0, chan_d_compare_mode_out)
		for (int i = 0; i < 8; i++) begin
			wr(8'h20, 32'h0000_0000, 4'h2);
			wr(8'h1C, {16'h0000, cm[i]}, 4'h3);
			wr(8'h20, 32'h0000_1100, 4'h2);
			c0 = cnt_c;
			d0 = cnt_d;
			pulses(src[i]);
			`CHK("events_c", ec[i], cnt_c - c0)
			`CHK("events_d", 8, cnt_d - d0)
		end
		// Held level passes the short filter on c and the cross route on d
		@(posedge clock_in);
		timer_input_c_in <= 1'b1;
		repeat (10) @(negedge clock_in);
		`CHK("capture_input_c", 1'b1, capture_input_c_out)
		`CHK("capture_input_d", 1'b1, capture_input_d_out)
		conclude();
	end
endmodule : testbench
